/* logic/ttws_params.svh */
/*
  offsets, field positions, reset values and timing figures of the
  trigger waveform unit; assumes a 100 MHz system clock
*/
`ifndef TTWS_PARAMS_SVH
`define TTWS_PARAMS_SVH

`define TTWS_OFF_CTRL        8'h00
`define TTWS_OFF_CYC_WIDTH   8'h04
`define TTWS_OFF_CNT_PAT     8'h08
`define TTWS_OFF_PULSE_WIDTH 8'h0C
`define TTWS_OFF_STATUS      8'h10

`define TTWS_CASC_EN_BIT     31
`define TTWS_TAIL_BIT        30
`define TTWS_WAVE_HI         22
`define TTWS_WAVE_LO         20
`define TTWS_ITER_HI         15
`define TTWS_CNT_HI          31
`define TTWS_CNT_LO          16

`define TTWS_RST_WORD        32'h0000_0000
`define TTWS_RST_HALF        16'h0000
`define TTWS_RST_WAVE        3'h0

`define TTWS_CLK_NS          10
`define TTWS_PW_STEP_NS      8
`define TTWS_MAX_OUT_KHZ     12500
`define TTWS_MIN_PERIOD_NS   (1000000 / `TTWS_MAX_OUT_KHZ)
`define TTWS_MIN_PHASE_NS    (`TTWS_MIN_PERIOD_NS / 2)

`endif

/* logic/ttws_pkg.sv */
/*
  types of the trigger waveform unit: waveform codes, states and the
  packed state of the unit; assumes ttws_params.svh alongside
*/
`default_nettype none
package ttws_pkg;

  typedef enum logic [2:0] {
    TTWS_W_FALL   = 3'h0,
    TTWS_W_RISE   = 3'h1,
    TTWS_W_NPULSE = 3'h2,
    TTWS_W_PPULSE = 3'h3,
    TTWS_W_NPER   = 3'h4,
    TTWS_W_PPER   = 3'h5,
    TTWS_W_PAT    = 3'h6,
    TTWS_W_RSVD   = 3'h7
  } ttws_wave_t;

  typedef enum logic [2:0] {
    TTWS_ST_IDLE,
    TTWS_ST_PULSE,
    TTWS_ST_ACT,
    TTWS_ST_INACT,
    TTWS_ST_PAT,
    TTWS_ST_DONE
  } ttws_st_t;

  typedef struct packed {
    ttws_st_t    st;
    logic        out;
    logic [33:0] t;
    logic [15:0] cyc;
    logic [20:0] bits;
    logic [3:0]  bit_i;
    logic        casc_en;
    logic        tail;
    ttws_wave_t  wave;
    logic [15:0] iter;
    logic [31:0] cw;
    logic [15:0] cnt;
    logic [15:0] pat;
    logic [15:0] pw;
    logic [31:0] rdata;
  } ttws_regs_t;

endpackage
`default_nettype wire

/* logic/ttws_top.sv */
/*
  trigger output waveform generator: edge, pulse, periodic and pattern
  output with cascade repeat count, plus its register port.
  assumes enable, time-reached and chain-tail inputs come from logic
  on the same clock.
*/
// Design decisions made here: the plain strobed port and the placing of the registers.
//
// Contract
// [R1] act only when enabled and time reached
// [R2] code 000: high to low, stays low
// [R3] code 001: low to high, stays high
// [R4] code 010: one low pulse, then high
// [R5] single high pulse of programmed width supported
// [R6] code 100: low periodic pulses, count or endless
// [R7] code 101: high periodic pulses, count or endless
// [R8] code 110: shift 16-bit pattern per bit period
// [R9] no toggling above 12.5 MHz ever; dropping enable sets the idle level at once, with no minimum phase
// [R10] 16-bit repeat count for tail unit
// [R11] repeat count means value plus one
// [R12] no tail in chain: repeat forever
// [R13] code 011 is the high pulse
// [R14] software avoids code 111; output stays idle
// [R15] pulse width in 8 ns steps, 16 bits
// [R16] period or bit period in 1 ns, 32 bits
// [R17] 16-bit cycle count, zero means unlimited
// [R18] tail flag per unit; none means endless
`timescale 1ns/1ps
`include "ttws_params.svh"
`default_nettype none
module ttws_top
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_trigger_unit_enable,
  input  wire logic        i_time_reached,
  input  wire logic        i_chain_tail_present,
  output logic             o_trig_out,
  output logic             o_busy,
  output logic             o_done
);
  import ttws_pkg::*;

  ttws_regs_t q;
  ttws_regs_t d;

  logic [33:0] pw_ns;
  logic [33:0] cw_ns;
  logic [33:0] inact_ns;
  logic [20:0] bit_lim;
  logic        bit_inf;
  logic        go;

  // end of a phase, never shorter than half the fastest period
  function automatic logic phase_end(input logic [33:0] t,
                                     input logic [33:0] lim);
    logic [33:0] l;
    l = (lim < 34'(`TTWS_MIN_PHASE_NS)) ? 34'(`TTWS_MIN_PHASE_NS) : lim; // R9
    return (t + 34'(`TTWS_CLK_NS)) >= l;
  endfunction

  // output level before the trigger
  function automatic logic idle_lvl(input ttws_wave_t w);
    return (w == TTWS_W_FALL) || (w == TTWS_W_NPULSE) || (w == TTWS_W_NPER);
  endfunction

  // running and finished decodes of the state
  function automatic logic is_busy(input ttws_st_t s);
    return (s != TTWS_ST_IDLE) && (s != TTWS_ST_DONE);
  endfunction

  function automatic logic is_done(input ttws_st_t s);
    return s == TTWS_ST_DONE;
  endfunction

  always_comb
  begin
    pw_ns    = 34'(q.pw) * 34'(`TTWS_PW_STEP_NS); // R15
    cw_ns    = 34'(q.cw); // R16
    inact_ns = (cw_ns > pw_ns) ? cw_ns - pw_ns : 34'h0;
    bit_lim  = 21'(q.cnt);
    bit_inf  = (q.cnt == `TTWS_RST_HALF);
    if (q.casc_en)
    begin
      if (!i_chain_tail_present && !q.tail)
      begin
        bit_inf = 1'b1; // R12 R18
      end
      else if (q.tail)
      begin
        bit_lim = (21'(q.iter) + 21'h1) << 4; // R10 R11
        bit_inf = 1'b0;
      end
    end
    go = i_trigger_unit_enable && i_time_reached; // R1
  end

  always_comb
  begin
    d       = q;
    d.rdata = `TTWS_RST_WORD;
    d.t     = q.t + 34'(`TTWS_CLK_NS);
    if (i_rd)
    begin
      case (i_addr)
        `TTWS_OFF_CTRL:
        begin
          d.rdata = {q.casc_en, q.tail, 7'h00, q.wave, 4'h0, q.iter};
        end
        `TTWS_OFF_CYC_WIDTH:
        begin
          d.rdata = q.cw;
        end
        `TTWS_OFF_CNT_PAT:
        begin
          d.rdata = {q.cnt, q.pat};
        end
        `TTWS_OFF_PULSE_WIDTH:
        begin
          d.rdata = {16'h0000, q.pw};
        end
        `TTWS_OFF_STATUS:
        begin
          d.rdata = {29'h0000_0000, is_done(q.st), is_busy(q.st), q.out};
        end
        default:
        begin
          d.rdata = `TTWS_RST_WORD;
        end
      endcase
    end
    if (i_wr)
    begin
      case (i_addr)
        `TTWS_OFF_CTRL:
        begin
          d.casc_en = i_wdata[`TTWS_CASC_EN_BIT];
          d.tail    = i_wdata[`TTWS_TAIL_BIT];
          d.wave    = ttws_wave_t'(i_wdata[`TTWS_WAVE_HI:`TTWS_WAVE_LO]);
          d.iter    = i_wdata[`TTWS_ITER_HI:0];
        end
        `TTWS_OFF_CYC_WIDTH:
        begin
          d.cw = i_wdata;
        end
        `TTWS_OFF_CNT_PAT:
        begin
          d.cnt = i_wdata[`TTWS_CNT_HI:`TTWS_CNT_LO]; // R17
          d.pat = i_wdata[15:0];
        end
        `TTWS_OFF_PULSE_WIDTH:
        begin
          d.pw = i_wdata[15:0];
        end
        default:
        begin
          d.cw = q.cw;
        end
      endcase
    end
    case (q.st)
      TTWS_ST_IDLE:
      begin
        d.out = idle_lvl(q.wave);
        d.t   = 34'h0;
        if (go)
        begin
          case (q.wave)
            TTWS_W_FALL:
            begin
              d.out = 1'b0; // R2
              d.st  = TTWS_ST_DONE;
            end
            TTWS_W_RISE:
            begin
              d.out = 1'b1; // R3
              d.st  = TTWS_ST_DONE;
            end
            TTWS_W_NPULSE:
            begin
              d.out = 1'b0; // R4
              d.st  = TTWS_ST_PULSE;
            end
            TTWS_W_PPULSE:
            begin
              d.out = 1'b1; // R5 R13
              d.st  = TTWS_ST_PULSE;
            end
            TTWS_W_NPER, TTWS_W_PPER:
            begin
              d.out = (q.wave == TTWS_W_PPER); // R6 R7
              d.cyc = 16'h0001;
              d.st  = TTWS_ST_ACT;
            end
            TTWS_W_PAT:
            begin
              d.out   = q.pat[0]; // R8
              d.bit_i = 4'h0;
              d.bits  = 21'h1;
              d.st    = TTWS_ST_PAT;
            end
            default:
            begin
              d.st = TTWS_ST_IDLE; // R14
            end
          endcase
        end
      end
      TTWS_ST_PULSE:
      begin
        if (phase_end(q.t, pw_ns))
        begin
          d.out = ~q.out; // R4 R5
          d.st  = TTWS_ST_DONE;
        end
      end
      TTWS_ST_ACT:
      begin
        if (phase_end(q.t, pw_ns))
        begin
          d.out = ~q.out;
          d.t   = 34'h0;
          d.st  = TTWS_ST_INACT;
        end
      end
      TTWS_ST_INACT:
      begin
        if (phase_end(q.t, inact_ns))
        begin
          d.t = 34'h0;
          if (q.cnt != `TTWS_RST_HALF && q.cyc >= q.cnt)
          begin
            d.st = TTWS_ST_DONE; // R6 R7 R17
          end
          else
          begin
            d.out = ~q.out;
            d.cyc = q.cyc + 16'h0001;
            d.st  = TTWS_ST_ACT;
          end
        end
      end
      TTWS_ST_PAT:
      begin
        if (phase_end(q.t, cw_ns))
        begin
          d.t = 34'h0;
          if (!bit_inf && q.bits >= bit_lim)
          begin
            d.out = 1'b0;
            d.st  = TTWS_ST_DONE; // R8 R11
          end
          else
          begin
            d.bit_i = q.bit_i + 4'h1;
            d.out   = q.pat[q.bit_i + 4'h1]; // R8
            d.bits  = bit_inf ? q.bits : q.bits + 21'h1;
          end
        end
      end
      TTWS_ST_DONE:
      begin
        d.st = TTWS_ST_DONE;
      end
      default:
      begin
        d.st = TTWS_ST_IDLE;
      end
    endcase
    if (!i_trigger_unit_enable)
    begin
      d.st  = TTWS_ST_IDLE; // R1
      d.out = idle_lvl(d.wave);
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      q         <= '0;
      q.st      <= TTWS_ST_IDLE;
      q.out     <= 1'b1;
      q.wave    <= ttws_wave_t'(`TTWS_RST_WAVE);
      q.cw      <= `TTWS_RST_WORD;
      q.cnt     <= `TTWS_RST_HALF;
      q.pat     <= `TTWS_RST_HALF;
      q.pw      <= `TTWS_RST_HALF;
      q.iter    <= `TTWS_RST_HALF;
      q.rdata   <= `TTWS_RST_WORD;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_rdata    = q.rdata;
  assign o_trig_out = q.out;
  assign o_busy     = is_busy(q.st);
  assign o_done     = is_done(q.st);

endmodule
`default_nettype wire

/* tb/ttws_top_props.sv */
/*
  checker of the trigger waveform unit
  bound to ttws_top; sees only its ports, one clock domain
*/
`timescale 1ns/1ps
`include "ttws_params.svh"
`default_nettype none
module ttws_top_props
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  input  wire logic        i_trigger_unit_enable,
  input  wire logic        i_time_reached,
  input  wire logic        o_trig_out,
  input  wire logic        o_busy,
  input  wire logic        o_done
);
  logic [2:0] wave_q;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  // shadow of the waveform code
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      wave_q <= 3'h0;
    else if (i_wr && i_addr == `TTWS_OFF_CTRL)
      wave_q <= i_wdata[`TTWS_WAVE_HI:`TTWS_WAVE_LO];
  end
  property p_idle;
    !o_busy && !o_done && !(i_trigger_unit_enable && i_time_reached) && !i_wr
      && !$past(i_wr) |=> $stable(o_trig_out);
  endproperty
  a_idle: assert property (p_idle) else $error("output moved while unarmed");
  property p_go;
    !o_busy && !o_done && i_trigger_unit_enable && i_time_reached && wave_q != 3'h7
      |=> o_busy || o_done;
  endproperty
  a_go: assert property (p_go) else $error("trigger not taken");
  property p_drop;
    !i_trigger_unit_enable |=> !o_busy && !o_done;
  endproperty
  a_drop: assert property (p_drop) else $error("disable ignored");
  property p_done;
    o_done |-> o_trig_out == (wave_q inside {3'h1, 3'h2, 3'h4});
  endproperty
  a_done: assert property (p_done) else $error("wrong final level");
  property p_phase;
    disable iff (i_rst || !i_trigger_unit_enable)
    $changed(o_trig_out) && o_busy |=> $stable(o_trig_out) [*3];
  endproperty
  a_phase: assert property (p_phase) else $error("phase under 40 ns");
  property p_end;
    $fell(o_busy) && $past(i_trigger_unit_enable) |-> o_done;
  endproperty
  a_end: assert property (p_end) else $error("run ended without done");
  property p_rsvd;
    wave_q == 3'h7 && !$past(i_wr) |-> !o_trig_out && !o_busy;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code acted");
  property p_rdata;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data without read");
endmodule

bind ttws_top ttws_top_props ttws_top_props_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_trigger_unit_enable(i_trigger_unit_enable), .i_time_reached(i_time_reached),
  .o_trig_out(o_trig_out), .o_busy(o_busy), .o_done(o_done));
`default_nettype wire

/* tb/ttws_top_tb.sv */
/*
  bench of ttws_top: table of waveform cases, then reset, bus and abort
  cases; one 100 MHz clock, all inputs driven here
*/
`timescale 1ns/1ps
`include "ttws_params.svh"
`default_nettype none
module ttws_top_tb;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] cw;
    logic [31:0] cp;
    logic [31:0] pw;
    logic        tail;
    int          tog;
    logic        fin;
    int          dur;
  } ttws_row_t;
  ttws_row_t   rows [13];
  logic        ref_clk = 1'h0;
  logic        rst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_s;
  logic        rd_s;
  logic [31:0] rdata;
  logic        en;
  logic        tr;
  logic        tail_p;
  logic        out;
  logic        busy;
  logic        done;
  int          bad_count = 0;
  int          tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  ttws_top ttws_top_i (.i_ref_clk(ref_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_trigger_unit_enable(en),
    .i_time_reached(tr), .i_chain_tail_present(tail_p), .o_trig_out(out), .o_busy(busy),
    .o_done(done));
  task automatic check(input logic ok);
    tests_run++;
    if (ok !== 1'h1)
    begin
      bad_count++;
      $display("BAD %0t unexpected value", $time);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr_s <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_s <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    rd_s <= 1'h1;
    addr <= a;
    @(posedge ref_clk);
    rd_s <= 1'h0;
    #1;
    check(rdata === e);
  endtask
  // program, arm, count level changes until done
  task automatic run(input ttws_row_t r);
    int   n;
    int   t;
    logic p;
    @(posedge ref_clk);
    en <= 1'h0;
    tail_p <= r.tail;
    wr(`TTWS_OFF_CTRL, r.ctrl);
    wr(`TTWS_OFF_CYC_WIDTH, r.cw);
    wr(`TTWS_OFF_CNT_PAT, r.cp);
    wr(`TTWS_OFF_PULSE_WIDTH, r.pw);
    rd(`TTWS_OFF_CTRL, r.ctrl);
    p = out;
    n = 0;
    t = 0;
    @(posedge ref_clk);
    en <= 1'h1;
    tr <= 1'h1;
    do
    begin
      @(posedge ref_clk);
      #1;
      n++;
      t += int'(out !== p);
      p = out;
    end
    while (done !== 1'h1 && n < 300);
    if (r.tog == 0)
      check(busy === r.fin);
    else
    begin
      check(t == r.tog);
      check(out === r.fin);
      check(r.dur == 0 || n == r.dur);
      rd(`TTWS_OFF_STATUS, {29'h0, 2'h2, r.fin});
    end
  endtask
  task results;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // longest run is capped at 300 cycles
  initial
  begin
    #300000;
    bad_count++;
    results();
  end
  initial
  begin
    rst = 1'h1;
    addr = 8'h0;
    wdata = 32'h0;
    wr_s = 1'h0;
    rd_s = 1'h0;
    en = 1'h0;
    tr = 1'h0;
    tail_p = 1'h0;
    rows = '{
      '{32'h0, 32'h0, 32'h0, 32'h0, 1'h0, 1, 1'h0, 0},
      '{32'h100000, 32'h0, 32'h0, 32'h0, 1'h0, 1, 1'h1, 0},
      '{32'h200000, 32'h0, 32'h0, 32'hA, 1'h0, 2, 1'h1, 9},
      '{32'h300000, 32'h0, 32'h0, 32'hA, 1'h0, 2, 1'h0, 9},
      '{32'h400000, 32'hC8, 32'h20000, 32'hA, 1'h0, 4, 1'h1, 41},
      '{32'h500000, 32'h14, 32'h10000, 32'h1, 1'h0, 2, 1'h0, 9},
      '{32'h600000, 32'h28, 32'h4000A, 32'h0, 1'h0, 4, 1'h0, 17},
      '{32'hC0600000, 32'h28, 32'h1, 32'h0, 1'h1, 2, 1'h0, 65},
      '{32'hC0600001, 32'h28, 32'h1, 32'h0, 1'h1, 4, 1'h0, 129},
      '{32'h400000, 32'hC8, 32'h0, 32'hA, 1'h0, 0, 1'h1, 0},
      '{32'h80600000, 32'h28, 32'h1, 32'h0, 1'h0, 0, 1'h1, 0},
      '{32'h80600000, 32'h28, 32'h20001, 32'h0, 1'h1, 2, 1'h0, 9},
      '{32'h700000, 32'h0, 32'h0, 32'h0, 1'h0, 0, 1'h0, 0}};
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    foreach (rows[k])
      run(rows[k]);
    @(posedge ref_clk);
    rst <= 1'h1;
    en <= 1'h0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    #1;
    check(out === 1'h1 && busy === 1'h0 && done === 1'h0);
    for (int k = 0; k < 4; k++)
      rd(8'(k * 4), 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0);
    rd(`TTWS_OFF_CTRL, 32'h0);
    wr(`TTWS_OFF_CTRL, 32'h200000);
    wr(`TTWS_OFF_PULSE_WIDTH, 32'hFFFF);
    tr <= 1'h0;
    en <= 1'h1;
    repeat (3) @(posedge ref_clk);
    #1;
    check(busy === 1'h0 && done === 1'h0 && out === 1'h1);
    @(posedge ref_clk);
    tr <= 1'h1;
    repeat (5) @(posedge ref_clk);
    #1;
    check(busy === 1'h1 && out === 1'h0);
    rd(`TTWS_OFF_STATUS, 32'h2);
    @(posedge ref_clk);
    en <= 1'h0;
    @(posedge ref_clk);
    #1;
    check(out === 1'h1 && busy === 1'h0);
    results();
  end
endmodule
`default_nettype wire
